// ===== auwc_pkg.sv
/*
 * Package for the arbiter and upstream window configuration bank.
 * Holds dword offsets, field positions and reset values.
 * Assumes a configuration access port that presents the byte offset of the dword.
 */
package auwc_pkg;
    localparam logic [7:0]  OFF_ARB_PRIO       = 8'h40;
    localparam logic [7:0]  OFF_EXT_UPWIN      = 8'h48;
    localparam logic [7:0]  OFF_PREEMPT        = 8'h4C;
    localparam logic [7:0]  OFF_UPWIN_BASELIM  = 8'h50;
    localparam logic [7:0]  OFF_UPWIN_BASE_HI  = 8'h54;
    localparam logic [7:0]  OFF_UPWIN_LIMIT_HI = 8'h58;
    localparam int          ARB_REQ_LSB        = 16;
    localparam int          ARB_REQ_MSB        = 24;
    localparam int          ARB_OWN_BIT        = 25;
    localparam int          EXT_FLOW_BIT       = 0;
    localparam int          EXT_PARK_BIT       = 1;
    localparam int          UPWIN_EN_BIT       = 16;
    localparam int          PRE_LSB            = 28;
    localparam int          PRE_MSB            = 31;
    localparam int          BASE_LSB           = 4;
    localparam int          BASE_MSB           = 15;
    localparam int          LIMIT_LSB          = 20;
    localparam int          LIMIT_MSB          = 31;
    localparam logic [8:0]  RST_REQ_PRIO       = 9'h000;
    localparam logic        RST_OWN_PRIO       = 1'b1;
    localparam logic        RST_FLOW_DIS       = 1'b0;
    localparam logic        RST_PARK           = 1'b0;
    localparam logic        RST_UPWIN_EN       = 1'b0;
    localparam logic [3:0]  RST_PREEMPT        = 4'h0;
    localparam logic [11:0] RST_BASE           = 12'h000;
    localparam logic [11:0] RST_LIMIT          = 12'h000;
    localparam logic [31:0] RST_HIGH           = 32'h0000_0000;
    localparam logic [3:0]  ADDR64_CAP         = 4'h1;
    localparam logic [31:0] DATA_ZERO          = 32'h0000_0000;
endpackage : auwc_pkg

// ===== auwc_preempt.sv
/*
 * Preemption timer for the secondary arbiter.
 * Assumes a one-cycle pulse marking FRAME assertion by the current master.
 */
`timescale 1ns/1ps
`default_nettype none
module auwc_preempt (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_code,
    input  wire logic       i_frame_start,
    input  wire logic       i_busy,
    output logic            o_preempt_ok
);
    logic [6:0] cnt;
    logic [6:0] limit;
    logic       running;

    // Code n below 8 maps to 0 for n=0, else 2^(n-1) clocks.
    always_comb begin
        if (i_code[2:0] == 3'h0) begin
            limit = 7'h00;
        end else begin
            limit = 7'(7'h01 << (i_code[2:0] - 3'h1));
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_busy) begin
            cnt     <= 7'h00;
            running <= 1'b0;
        end else if (i_frame_start) begin
            cnt     <= 7'h00;
            running <= 1'b1;
        end else if (running && cnt != 7'h7F) begin
            cnt <= cnt + 7'h01;
        end
    end

    // Counting starts at the FRAME pulse, so a zero delay allows preemption at once.
    // The sum is one bit wider so that a saturated count cannot wrap below the limit.
    assign o_preempt_ok = !i_code[3] && i_busy &&
                          ((i_frame_start && limit == 7'h00) ||
                           (running && !i_frame_start &&
                            ({1'b0, cnt} + 8'h01) >= {1'b0, limit}));
endmodule : auwc_preempt
`default_nettype wire

// ===== auwc_bank.sv
/*
 * Arbiter, flow-through and upstream memory window configuration bank.
 * Assumes single-cycle configuration writes and reads with byte enables,
 * addressed by the byte offset of the dword, all on the PCI clock.
 */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module auwc_bank (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    output logic [31:0]      o_cfg_rdata,
    output logic             o_cfg_hit,
    input  wire logic [63:0] i_sec_addr,
    input  wire logic        i_in_down_window,
    input  wire logic        i_frame_start,
    input  wire logic        i_bus_busy,
    output logic [8:0]       o_req_high_prio,
    output logic             o_own_high_prio,
    output logic             o_flow_thru_dis,
    output logic             o_park_on_bridge,
    output logic             o_preempt_ok,
    output logic             o_upstream_claim
);
    logic [8:0]  req_prio;
    logic        own_prio;
    logic        flow_dis;
    logic        park;
    logic        upwin_en;
    logic [3:0]  preempt;
    logic [11:0] base;
    logic [11:0] limit;
    logic [31:0] base_hi;
    logic [31:0] limit_hi;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic        hit;
    logic [63:0] win_lo;
    logic [63:0] win_hi;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and byte lane mask.
    assign wmask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

    always_comb begin
        hit = 1'b1;
        unique case (i_cfg_addr)
            auwc_pkg::OFF_ARB_PRIO,
            auwc_pkg::OFF_EXT_UPWIN,
            auwc_pkg::OFF_PREEMPT,
            auwc_pkg::OFF_UPWIN_BASELIM,
            auwc_pkg::OFF_UPWIN_BASE_HI,
            auwc_pkg::OFF_UPWIN_LIMIT_HI: hit = 1'b1;
            default:                      hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbiter priority word.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            req_prio <= auwc_pkg::RST_REQ_PRIO;
            own_prio <= auwc_pkg::RST_OWN_PRIO;
        end else if (i_cfg_wr && i_cfg_addr == auwc_pkg::OFF_ARB_PRIO) begin
            if (i_cfg_be[2]) begin
                req_prio[7:0] <= i_cfg_wdata[23:16];
            end
            if (i_cfg_be[3]) begin
                req_prio[8] <= i_cfg_wdata[auwc_pkg::ARB_REQ_MSB];
                own_prio    <= i_cfg_wdata[auwc_pkg::ARB_OWN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Extended control and upstream window enable share one dword.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            flow_dis <= auwc_pkg::RST_FLOW_DIS;
            park     <= auwc_pkg::RST_PARK;
            upwin_en <= auwc_pkg::RST_UPWIN_EN;
        end else if (i_cfg_wr && i_cfg_addr == auwc_pkg::OFF_EXT_UPWIN) begin
            if (i_cfg_be[0]) begin
                flow_dis <= i_cfg_wdata[auwc_pkg::EXT_FLOW_BIT];
                park     <= i_cfg_wdata[auwc_pkg::EXT_PARK_BIT];
            end
            if (i_cfg_be[2]) begin
                upwin_en <= i_cfg_wdata[auwc_pkg::UPWIN_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Preemption delay code.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            preempt <= auwc_pkg::RST_PREEMPT;
        end else if (i_cfg_wr && i_cfg_addr == auwc_pkg::OFF_PREEMPT && i_cfg_be[3]) begin
            preempt <= i_cfg_wdata[auwc_pkg::PRE_MSB:auwc_pkg::PRE_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Upstream window base and limit, low and high halves.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            base  <= auwc_pkg::RST_BASE;
            limit <= auwc_pkg::RST_LIMIT;
        end else if (i_cfg_wr && i_cfg_addr == auwc_pkg::OFF_UPWIN_BASELIM) begin
            if (i_cfg_be[0]) begin
                base[3:0] <= i_cfg_wdata[7:4];
            end
            if (i_cfg_be[1]) begin
                base[11:4] <= i_cfg_wdata[auwc_pkg::BASE_MSB:8];
            end
            if (i_cfg_be[2]) begin
                limit[3:0] <= i_cfg_wdata[23:auwc_pkg::LIMIT_LSB];
            end
            if (i_cfg_be[3]) begin
                limit[11:4] <= i_cfg_wdata[auwc_pkg::LIMIT_MSB:24];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            base_hi <= auwc_pkg::RST_HIGH;
        end else if (i_cfg_wr && i_cfg_addr == auwc_pkg::OFF_UPWIN_BASE_HI) begin
            base_hi <= (base_hi & ~wmask) | (i_cfg_wdata & wmask);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            limit_hi <= auwc_pkg::RST_HIGH;
        end else if (i_cfg_wr && i_cfg_addr == auwc_pkg::OFF_UPWIN_LIMIT_HI) begin
            limit_hi <= (limit_hi & ~wmask) | (i_cfg_wdata & wmask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unlisted bits stay zero.
    always_comb begin
        rd_word = auwc_pkg::DATA_ZERO;
        unique case (i_cfg_addr)
            auwc_pkg::OFF_ARB_PRIO: begin
                rd_word[auwc_pkg::ARB_REQ_MSB:auwc_pkg::ARB_REQ_LSB] = req_prio;
                rd_word[auwc_pkg::ARB_OWN_BIT] = own_prio;
            end
            auwc_pkg::OFF_EXT_UPWIN: begin
                rd_word[auwc_pkg::EXT_FLOW_BIT] = flow_dis;
                rd_word[auwc_pkg::EXT_PARK_BIT] = park;
                rd_word[auwc_pkg::UPWIN_EN_BIT] = upwin_en;
            end
            auwc_pkg::OFF_PREEMPT: begin
                rd_word[auwc_pkg::PRE_MSB:auwc_pkg::PRE_LSB] = preempt;
            end
            auwc_pkg::OFF_UPWIN_BASELIM: begin
                rd_word[3:0]   = auwc_pkg::ADDR64_CAP;
                rd_word[auwc_pkg::BASE_MSB:auwc_pkg::BASE_LSB] = base;
                rd_word[19:16] = auwc_pkg::ADDR64_CAP;
                rd_word[auwc_pkg::LIMIT_MSB:auwc_pkg::LIMIT_LSB] = limit;
            end
            auwc_pkg::OFF_UPWIN_BASE_HI:  rd_word = base_hi;
            auwc_pkg::OFF_UPWIN_LIMIT_HI: rd_word = limit_hi;
            default:                      rd_word = auwc_pkg::DATA_ZERO;
        endcase
    end

    // Read data is registered; it appears the cycle after the read strobe.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_cfg_rdata <= auwc_pkg::DATA_ZERO;
            o_cfg_hit   <= 1'b0;
        end else begin
            o_cfg_hit <= (i_cfg_rd || i_cfg_wr) && hit;
            if (i_cfg_rd) begin
                o_cfg_rdata <= hit ? rd_word : auwc_pkg::DATA_ZERO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Upstream claim decode.
    assign win_lo = {base_hi, base, 20'h00000};
    assign win_hi = {limit_hi, limit, 20'hFFFFF};

    always_comb begin
        if (upwin_en) begin
            o_upstream_claim = (i_sec_addr >= win_lo) && (i_sec_addr <= win_hi);
        end else begin
            o_upstream_claim = !i_in_down_window;
        end
    end

    assign o_req_high_prio  = req_prio;
    assign o_own_high_prio  = own_prio;
    assign o_flow_thru_dis  = flow_dis;
    assign o_park_on_bridge = park;

    auwc_preempt u_preempt (
        .i_core_clk    (i_core_clk),
        .i_rst         (i_rst),
        .i_code        (preempt),
        .i_frame_start (i_frame_start),
        .i_busy        (i_bus_busy),
        .o_preempt_ok  (o_preempt_ok)
    );
endmodule : auwc_bank
`default_nettype wire

// ===== auwc_bank_checker.sv
/* Assertions on the ports of the configuration bank.
   Assumes it is bound into auwc_bank. */
`timescale 1ns/1ps
`default_nettype none
module auwc_bank_checker (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_cfg_wr,
    input wire logic        i_cfg_rd,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic [3:0]  i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_cfg_hit,
    input wire logic        i_in_down_window,
    input wire logic [8:0]  o_req_high_prio,
    input wire logic        o_own_high_prio,
    input wire logic        o_flow_thru_dis,
    input wire logic        o_park_on_bridge,
    input wire logic        o_preempt_ok,
    input wire logic        o_upstream_claim
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic map;
    logic wr40;
    logic en;
    assign map = i_cfg_addr inside {8'h40, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58};
    assign wr40 = i_cfg_wr && i_cfg_addr == 8'h40;
    // Shadow of the window enable; the bank does not bring it out.
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            en <= 1'b0;
        else if (i_cfg_wr && i_cfg_addr == 8'h48 && i_cfg_be[2])
            en <= i_cfg_wdata[16];
    end
    ////////////////////////////////////////
    property p_unmap; i_cfg_rd && !map |=> o_cfg_rdata == 32'h0 && !o_cfg_hit; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_arb; i_cfg_rd && i_cfg_addr == 8'h40 |=> o_cfg_rdata ==
        {6'h0, $past(o_own_high_prio), $past(o_req_high_prio), 16'h0}; endproperty
    a_arb: assert property (p_arb) else $error("arbiter word");
    property p_ext; i_cfg_rd && i_cfg_addr == 8'h48 |=> o_cfg_rdata[31:17] == 15'h0 &&
        o_cfg_rdata[15:0] == {14'h0, $past(o_park_on_bridge), $past(o_flow_thru_dis)}; endproperty
    a_ext: assert property (p_ext) else $error("extended word");
    property p_cap; i_cfg_rd && i_cfg_addr == 8'h50 |=>
        o_cfg_rdata[3:0] == 4'h1 && o_cfg_rdata[19:16] == 4'h1; endproperty
    a_cap: assert property (p_cap) else $error("capability nibbles");
    property p_own; wr40 && i_cfg_be[3] |=> o_own_high_prio == $past(i_cfg_wdata[25]); endproperty
    a_own: assert property (p_own) else $error("own priority write");
    property p_req; wr40 && i_cfg_be[2] |=>
        o_req_high_prio[7:0] == $past(i_cfg_wdata[23:16]); endproperty
    a_req: assert property (p_req) else $error("request priority write");
    property p_hold; !wr40 |=> $stable(o_own_high_prio) && $stable(o_req_high_prio); endproperty
    a_hold: assert property (p_hold) else $error("priority moved");
    property p_off; !en |-> o_upstream_claim == !i_in_down_window; endproperty
    a_off: assert property (p_off) else $error("window off claim");
    c_hit: cover property (o_cfg_hit);
    c_pre: cover property ($rose(o_preempt_ok));
    c_clm: cover property (en && o_upstream_claim);
endmodule : auwc_bank_checker
bind auwc_bank auwc_bank_checker i_auwc_bank_checker (.i_core_clk, .i_rst, .i_cfg_wr,
    .i_cfg_rd, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_hit,
    .i_in_down_window, .o_req_high_prio, .o_own_high_prio, .o_flow_thru_dis,
    .o_park_on_bridge, .o_preempt_ok, .o_upstream_claim);
`default_nettype wire

// ===== tb_top.sv
/* Self-checking testbench for the configuration bank.
   Assumes the checker is bound in; drives inputs on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_core_clk, i_rst, i_cfg_wr, i_cfg_rd, i_frame_start, i_bus_busy;
    logic        i_in_down_window, o_cfg_hit, o_own_high_prio, o_flow_thru_dis;
    logic        o_park_on_bridge, o_preempt_ok, o_upstream_claim;
    logic [7:0]  i_cfg_addr;
    logic [3:0]  i_cfg_be;
    logic [31:0] i_cfg_wdata, o_cfg_rdata;
    logic [63:0] i_sec_addr;
    logic [8:0]  o_req_high_prio;
    int          n_errors, n_compared, k, d;
    logic [7:0]  offs [7] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58};
    logic [31:0] rst_v [7] = '{32'h0200_0000, 32'h0, 32'h0, 32'h0, 32'h0001_0001, 32'h0, 32'h0};
    logic [31:0] one_v [7] = '{32'h03FF_0000, 32'h0, 32'h0001_0003, 32'hF000_0000,
                               32'hFFF1_FFF1, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    // Each window end is straddled by one so an off-by-one compare shows.
    logic [63:0] adr [5] = '{64'h1_000F_FFFF, 64'h1_0010_0000, 64'h1_002F_FFFF,
                             64'h1_0030_0000, 64'h0_0010_0000};
    logic        clm [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    auwc_bank i_auwc_bank (.i_core_clk, .i_rst, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_be,
        .i_cfg_wdata, .o_cfg_rdata, .o_cfg_hit, .i_sec_addr, .i_in_down_window,
        .i_frame_start, .i_bus_busy, .o_req_high_prio, .o_own_high_prio, .o_flow_thru_dis,
        .o_park_on_bridge, .o_preempt_ok, .o_upstream_claim);
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        @(negedge i_core_clk);
        i_cfg_wr = 1'b1;
        i_cfg_addr = a;
        i_cfg_be = be;
        i_cfg_wdata = v;
        @(negedge i_core_clk);
        i_cfg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge i_core_clk);
        i_cfg_rd = 1'b1;
        i_cfg_addr = a;
        @(negedge i_core_clk);
        i_cfg_rd = 1'b0;
        chk("hit and read data", 64'({a != 8'h44, e}), 64'({o_cfg_hit, o_cfg_rdata}));
    endtask : rd
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    initial begin
        {i_cfg_wr, i_cfg_rd, i_frame_start, i_bus_busy, i_in_down_window} = 5'h00;
        {i_cfg_addr, i_cfg_be, i_cfg_wdata, i_sec_addr} = 108'h0;
        i_rst = 1'b1;
        repeat (16) @(negedge i_core_clk);
        i_rst = 1'b0;
        for (int i = 0; i < 7; i++) rd(offs[i], rst_v[i]);
        for (int i = 0; i < 7; i++) wr(offs[i], 4'hF, 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++) rd(offs[i], one_v[i]);
        chk("config levels", 64'h0FFF, 64'({o_req_high_prio, o_own_high_prio,
            o_flow_thru_dis, o_park_on_bridge}));
        wr(8'h40, 4'h4, 32'h0);
        rd(8'h40, 32'h0300_0000);
        wr(8'h48, 4'h3, 32'h0);
        rd(8'h48, 32'h0001_0000);
        chk("config levels", 64'h0804, 64'({o_req_high_prio, o_own_high_prio,
            o_flow_thru_dis, o_park_on_bridge}));
        wr(8'h50, 4'hF, 32'h0020_0010);
        wr(8'h54, 4'hF, 32'h1);
        wr(8'h58, 4'hF, 32'h1);
        for (int i = 0; i < 5; i++) begin
            @(negedge i_core_clk);
            i_sec_addr = adr[i];
            #1 chk("window claim", 64'(clm[i]), 64'(o_upstream_claim));
        end
        wr(8'h48, 4'h4, 32'h0);
        for (int j = 0; j < 2; j++) begin
            @(negedge i_core_clk);
            i_in_down_window = j[0];
            #1 chk("open claim", 64'(!j[0]), 64'(o_upstream_claim));
        end
        for (int c = 0; c < 9; c++) begin
            wr(8'h4C, 4'h8, {c[3:0], 28'h0});
            d = c[3] ? 80 : (c == 0 ? 0 : 1 << (c - 1));
            // Busy was dropped after the last run, so each delay starts from a cleared timer.
            // The cycle that carries the FRAME pulse is cycle zero of the count.
            @(negedge i_core_clk);
            i_bus_busy = 1'b1;
            i_frame_start = 1'b1;
            k = 0;
            #1;
            while (o_preempt_ok !== 1'b1 && k < 80) begin
                @(negedge i_core_clk);
                i_frame_start = 1'b0;
                k++;
                #1;
            end
            chk("preempt delay", 64'(d), 64'(k));
            i_bus_busy = 1'b0;
        end
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
